// ---- rtl/reset_source_pkg.sv ----
// Constants for the reset source status register pair
package reset_source_pkg;
  localparam logic [7:0]  OFFSET_PRODUCT_IDENTIFIER = 8'h00;
  localparam logic [7:0]  OFFSET_RESET_CAUSE_FLAGS  = 8'h04;
  localparam int          POS_CORE_RESET            = 0;
  localparam int          POS_PIN_RESET             = 1;
  localparam int          POS_WATCHDOG              = 2;
  localparam int          POS_LOW_VOLTAGE           = 3;
  localparam int          POS_CORE_REQUEST          = 5;
  localparam int          POS_POWER_MANAGEMENT      = 6;
  localparam int          POS_PROCESSOR_RESET       = 7;
  localparam int          POS_WAKEUP_PIN            = 8;
  localparam int          POS_TIMER_WAKEUP          = 9;
  localparam int          POS_POWER_ON              = 10;
  localparam logic [31:0] FLAG_MASK                 = 32'h0000_07EF;
  localparam logic [31:0] POWER_UP_MASK             = 32'h0000_0700;
  localparam logic [31:0] FLAGS_RESET               = 32'h0000_0000;
  localparam logic [1:0]  ONE_SHOT_CYCLES           = 2'h2;
endpackage : reset_source_pkg

// ---- rtl/one_shot_if.sv ----
// Handshake between the flag bank and the one-shot reset pulser
`timescale 1ns/1ps
interface one_shot_if;
  logic start;
  logic active;
  logic fired;
  modport ctrl  (output start, input active, input fired);
  modport timer (input start, output active, output fired);
endinterface : one_shot_if

// ---- rtl/one_shot_pulser.sv ----
// Two-cycle self-clearing processor reset pulse
`timescale 1ns/1ps
module one_shot_pulser
  import reset_source_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  one_shot_if.timer port
);
  typedef struct packed {
    logic [1:0] count;
    logic       active;
    logic       fired;
  } pulser_state_t;

  pulser_state_t state;
  pulser_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.fired = 1'b0;
    if (state.active) begin
      if (state.count == ONE_SHOT_CYCLES - 2'h1) begin
        next_state.active = 1'b0;
        next_state.count  = 2'h0;
        next_state.fired  = 1'b1;
      end else begin
        next_state.count = state.count + 2'h1;
      end
    end else if (port.start) begin
      next_state.active = 1'b1;
      next_state.count  = 2'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign port.active = state.active;
  assign port.fired  = state.fired;
endmodule : one_shot_pulser

// ---- rtl/reset_source_status.sv ----
// Product identifier and sticky reset cause flags
`timescale 1ns/1ps
module reset_source_status
  import reset_source_pkg::*;
#(
  parameter logic [31:0] PART_IDENTIFIER = 32'h0000_0001  // Arbitrary value
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        reg_sel,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        processor_one_shot_reset,
  input  wire logic        power_on_event,
  input  wire logic        timer_wakeup_event,
  input  wire logic        wakeup_pin_event,
  input  wire logic        power_management_event,
  input  wire logic        core_system_reset_request,
  input  wire logic        low_voltage_event,
  input  wire logic        watchdog_event,
  input  wire logic        reset_pin_event,
  output logic             processor_reset,
  output logic             flash_controller_reset
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] rdata;
    logic        cpu_reset;
    logic [8:0]  sync1;
    logic [8:0]  sync2;
    logic [8:0]  sync3;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;
  one_shot_if  shot ();
  logic [8:0]  raw_events;
  logic [8:0]  rise;
  logic [31:0] set_bits;
  logic [31:0] clear_bits;
  logic        flag_write;

  // ---------------------------------------------------------------
  // One-shot pulser
  // ---------------------------------------------------------------
  one_shot_pulser u_pulser (
    .ref_clk (ref_clk),
    .rst     (rst),
    .port    (shot.timer)
  );

  assign flag_write = reg_sel && reg_write
                      && (reg_addr == OFFSET_RESET_CAUSE_FLAGS);
  assign shot.start = processor_one_shot_reset;

  assign raw_events = {power_on_event, timer_wakeup_event,
                       wakeup_pin_event, power_management_event,
                       core_system_reset_request, low_voltage_event,
                       watchdog_event, reset_pin_event, 1'b0};
  assign rise = state.sync2 & ~state.sync3;

  // ---------------------------------------------------------------
  // Flag update
  // ---------------------------------------------------------------
  always_comb begin
    set_bits = '0;
    set_bits[POS_POWER_ON]         = rise[8];
    set_bits[POS_TIMER_WAKEUP]     = rise[7];
    set_bits[POS_WAKEUP_PIN]       = rise[6];
    set_bits[POS_POWER_MANAGEMENT] = rise[5];
    set_bits[POS_CORE_REQUEST]     = rise[4];
    set_bits[POS_LOW_VOLTAGE]      = rise[3];
    set_bits[POS_WATCHDOG]         = rise[2];
    set_bits[POS_PIN_RESET]        = rise[1];
    set_bits[POS_PROCESSOR_RESET]  = shot.fired;
    set_bits[POS_CORE_RESET]       = rise[8] | rise[1]
                                     | rise[5];
    clear_bits = '0;
    if (flag_write) begin
      clear_bits = reg_wdata & FLAG_MASK;
      if ((reg_wdata & POWER_UP_MASK) != 32'h0000_0000) begin
        clear_bits = clear_bits | POWER_UP_MASK;
      end
    end
  end

  always_comb begin
    next_state = state;
    next_state.sync1 = raw_events;
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    // Set beats clear; zeros leave flags alone, except that a one in any of bits 8-10 clears all three
    next_state.flags = ((state.flags & ~clear_bits) | set_bits)
                       & FLAG_MASK;
    next_state.cpu_reset = shot.active;
    case (reg_addr)
      OFFSET_PRODUCT_IDENTIFIER: next_state.rdata = PART_IDENTIFIER;
      OFFSET_RESET_CAUSE_FLAGS:  next_state.rdata = state.flags;
      default:                   next_state.rdata = 32'h0000_0000;
    endcase
  end

  // Flags live only on the global reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata              = state.rdata;
  assign processor_reset        = state.cpu_reset;
  assign flash_controller_reset = state.cpu_reset;
endmodule : reset_source_status

// ---- tb/reset_source_status_props.sv ----
// Checker for the reset source status ports
`timescale 1ns/1ps
module reset_source_status_props
  import reset_source_pkg::*;
#(
  parameter logic [31:0] PART_IDENTIFIER = 32'h0000_0001
)
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        reg_sel,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic        processor_one_shot_reset,
  input wire logic        processor_reset,
  input wire logic        flash_controller_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reserved_read_zero: assert property (
    (!$past(rst) && $past(reg_addr) == OFFSET_RESET_CAUSE_FLAGS)
    |-> ((reg_rdata & ~FLAG_MASK) == 32'h0000_0000))
    else $error("reserved bits read nonzero");
  a_unmapped_read_zero: assert property (
    (!$past(rst) && $past(reg_addr) != OFFSET_RESET_CAUSE_FLAGS
     && $past(reg_addr) != OFFSET_PRODUCT_IDENTIFIER)
    |-> (reg_rdata == 32'h0000_0000))
    else $error("unmapped address read nonzero");
  a_identifier_read: assert property (
    (!$past(rst) && $past(reg_addr) == OFFSET_PRODUCT_IDENTIFIER)
    |-> (reg_rdata == PART_IDENTIFIER))
    else $error("identifier read wrong");
  a_pulse_two_cycles: assert property (
    $rose(processor_reset) |=> processor_reset ##1 !processor_reset)
    else $error("processor reset pulse length wrong");
  a_flash_follows_core: assert property (
    processor_reset == flash_controller_reset)
    else $error("flash reset differs from processor reset");
  a_one_shot_starts: assert property (
    (processor_one_shot_reset && !processor_reset)
    |-> ##[1:2] processor_reset)
    else $error("one-shot gave no pulse");
  a_pulse_has_cause: assert property (
    $rose(processor_reset)
    |-> ($past(processor_one_shot_reset)
         || $past(processor_one_shot_reset, 2)))
    else $error("processor reset pulse without cause");
  a_flags_stay_set: assert property (
    (!$past(rst) && !$past(rst, 2)
     && $past(reg_addr) == OFFSET_RESET_CAUSE_FLAGS
     && $past(reg_addr, 2) == OFFSET_RESET_CAUSE_FLAGS
     && !$past(reg_sel && reg_write, 2))
    |-> ((reg_rdata & $past(reg_rdata)) == $past(reg_rdata)))
    else $error("reset cause flag lost without clear");
  c_pulse: cover property ($rose(processor_reset));
  c_flags_read: cover property ($past(reg_addr) == 8'h04 && reg_rdata != 0);
  c_clear: cover property (reg_sel && reg_write && reg_addr == 8'h04);
endmodule : reset_source_status_props
bind reset_source_status reset_source_status_props #(.PART_IDENTIFIER(
  PART_IDENTIFIER)) u_props (.ref_clk(ref_clk), .rst(rst), .reg_sel(reg_sel),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .processor_one_shot_reset(processor_one_shot_reset),
  .processor_reset(processor_reset),
  .flash_controller_reset(flash_controller_reset));

// ---- tb/test_reset_source_status.sv ----
// Self-checking bench for the reset source status block
`timescale 1ns/1ps
module test_reset_source_status
  import reset_source_pkg::*;
;
  logic ref_clk = 0, rst = 1, reg_sel = 0, reg_write = 0, one_shot = 0;
  logic [7:0] reg_addr = 8'h00, ev = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, exp = 32'h0;
  logic pr, fr;
  int err_total = 0, total_checks = 0, i;
  always #25 ref_clk = ~ref_clk;
  reset_source_status u_reset_source_status (.ref_clk(ref_clk), .rst(rst),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .processor_one_shot_reset(one_shot), .power_on_event(ev[7]),
    .timer_wakeup_event(ev[6]), .wakeup_pin_event(ev[5]),
    .power_management_event(ev[4]), .core_system_reset_request(ev[3]),
    .low_voltage_event(ev[2]), .watchdog_event(ev[1]),
    .reset_pin_event(ev[0]), .processor_reset(pr),
    .flash_controller_reset(fr));
  // Flags each event must set, power-on first
  logic [31:0] sets [8] = '{32'h0000_0401,
                            32'h0000_0200,
                            32'h0000_0100,
                            32'h0000_0041,
                            32'h0000_0020,
                            32'h0000_0008,
                            32'h0000_0004,
                            32'h0000_0003};
  task chk(input string what, input logic [31:0] want, got);
    total_checks++;
    if (got !== want) begin
      $display("BAD %s expected %h seen %h", what, want, got);
      err_total++;
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge ref_clk) #1 {reg_sel, reg_write, reg_addr} = {2'b10, a};
    @(posedge ref_clk) #1 reg_sel = 0;
    chk("read data", want, reg_rdata);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) #1 {reg_sel, reg_write, reg_addr} = {2'b11, a};
    reg_wdata = d;
    @(posedge ref_clk) #1 {reg_sel, reg_write} = 2'b00;
  endtask : wr
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task scen_map;
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_0001);
    rd(8'h08, 32'h0000_0000);
  endtask : scen_map
  task scen_events;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk) #1 ev[7-i] = 1;
      repeat (5) @(posedge ref_clk);
      #1 ev[7-i] = 0;
      exp = exp | sets[i];
      rd(8'h04, exp);
    end
  endtask : scen_events
  task scen_clear;
    wr(8'h04, 32'hFFFF_F810);
    rd(8'h04, exp);
    wr(8'h04, 32'h0000_0200);
    rd(8'h04, 32'h0000_006F);
    wr(8'h04, 32'h0000_0004);
    rd(8'h04, 32'h0000_006B);
  endtask : scen_clear
  task scen_one_shot;
    @(posedge ref_clk) #1 one_shot = 1;
    @(posedge ref_clk) #1 one_shot = 0;
    for (i = 0; i < 4 && pr !== 1'b1; i++) @(posedge ref_clk) #1;
    if (i == 4) begin err_total++; tally_and_finish; end
    @(posedge ref_clk) #1 chk("second cycle", 1'b1, pr);
    chk("flash second cycle", 1'b1, fr);
    @(posedge ref_clk) #1 chk("self clear", 1'b0, pr);
    chk("flash self clear", 1'b0, fr);
    rd(8'h04, 32'h0000_00EB);
  endtask : scen_one_shot
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 rst = 0;
    scen_map;
    scen_events;
    scen_clear;
    scen_one_shot;
    tally_and_finish;
  end
endmodule : test_reset_source_status
